// ===== common/tsf_pkg.sv
// Constants, types and helpers shared by the trace stream formatter.
package tsf_pkg;

  typedef enum logic [1:0] {
    TSF_MODE_BYPASS = 2'h0,
    TSF_MODE_NORMAL = 2'h1,
    TSF_MODE_CONT = 2'h2
  } tsf_mode_t;

  typedef enum logic [2:0] {
    TSF_OS_IDLE = 3'h0,
    TSF_OS_SYNC = 3'h1,
    TSF_OS_FRAME = 3'h3,
    TSF_OS_HSYNC = 3'h2,
    TSF_OS_BYP = 3'h6,
    TSF_OS_TAIL = 3'h7
  } tsf_ostate_t;

  localparam logic [3:0] TSF_SLOT_LAST = 4'hE;
  localparam logic [3:0] TSF_FRAME_LAST = 4'hF;
  localparam logic [3:0] TSF_SYNC_LAST = 4'h3;
  localparam logic [6:0] TSF_ID_NULL = 7'h00;
  localparam logic [6:0] TSF_ID_RSV_LO = 7'h70;
  localparam logic [6:0] TSF_ID_FLUSH = 7'h7B;
  localparam logic [6:0] TSF_ID_TRIG = 7'h7D;
  localparam logic [7:0] TSF_FLUSH_ALL = 8'h00;
  localparam logic [7:0] TSF_NULL_DATA = 8'h00;
  localparam logic [7:0] TSF_TAIL_MARK = 8'h01;
  localparam logic [31:0] TSF_FSYNC_WORD = 32'h7FFFFFFF;
  localparam logic [15:0] TSF_HSYNC_HALF = 16'h7FFF;
  localparam int TSF_ID_REPEAT_FRAMES = 10;
  localparam int TSF_FSYNC_FRAMES = 8;
  localparam logic [6:0] TSF_RST_ID = 7'h00;
  localparam logic [7:0] TSF_RST_CNT = 8'h00;

  // outside bypass mode, sources may use only ordinary IDs (not null, below the reserved range)
  function automatic logic tsf_id_usable(input logic [6:0] id);
    return (id != TSF_ID_NULL) && (id < TSF_ID_RSV_LO);
  endfunction : tsf_id_usable

  function automatic logic [7:0] tsf_id_byte(input logic [6:0] id);
    return {id, 1'b1};
  endfunction : tsf_id_byte

endpackage : tsf_pkg

// ===== rtl/tsf_formatter.sv
// Trace stream formatter top: input stage, frame assembly, flush and trigger handling.
`timescale 1ns/1ps
`default_nettype none
module tsf_formatter #(
  parameter int ID_REPEAT_FRAMES = tsf_pkg::TSF_ID_REPEAT_FRAMES,
  parameter int FSYNC_FRAMES = tsf_pkg::TSF_FSYNC_FRAMES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [1:0] mode_i,
  input wire logic src_valid_i,
  input wire logic [6:0] src_id_i,
  input wire logic [7:0] src_data_i,
  output logic src_ready_o,
  input wire logic trig_valid_i,
  input wire logic [7:0] trig_id_i,
  input wire logic flush_i,
  output logic flush_done_o,
  output logic [7:0] trace_data_o,
  output logic trace_valid_control_pin_o
);

  localparam logic [7:0] REP_LAST = 8'(ID_REPEAT_FRAMES - 1);

  // ==========================================================
  // state
  logic inq_v, next_inq_v;
  logic [6:0] inq_id, next_inq_id;
  logic [7:0] inq_data, next_inq_data;
  logic next_src_ready;
  logic hold_v, next_hold_v;
  logic [6:0] hold_id, next_hold_id;
  logic [7:0] hold_data, next_hold_data;
  logic [3:0] pos, next_pos;
  logic [6:0] cur_id, next_cur_id;
  logic [7:0] fb [15];
  logic [7:0] next_fb [15];
  logic [7:0] aux, next_aux;
  logic full, next_full;
  logic old_ok, next_old_ok;
  logic force_rep, next_force_rep;
  logic [7:0] rep_cnt, next_rep_cnt;
  logic trig_pend, next_trig_pend;
  logic [7:0] trig_id_q, next_trig_id_q;
  logic flush_pend, next_flush_pend;
  logic resp_sent, next_resp_sent;
  logic tail_req, next_tail_req;
  logic next_flush_done;

  // ==========================================================
  // working signals
  logic fmt;
  logic p_v;
  logic [1:0] p_src;
  logic [6:0] p_id;
  logic [7:0] p_data;
  logic [6:0] tgt;
  logic wr;
  logic [7:0] wbyte;
  logic waux;
  logic id_wr;
  logic consume;
  logic frame_done;
  logic [127:0] frame_bus;
  logic frame_take;
  logic byp_take;
  logic tail_done;

  tsf_out #(
    .FSYNC_FRAMES(FSYNC_FRAMES)
  ) u_out (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .mode_i(mode_i),
    .frame_valid_i(full),
    .frame_i(frame_bus),
    .frame_take_o(frame_take),
    .byp_valid_i(inq_v && !fmt),
    .byp_data_i(inq_data),
    .byp_take_o(byp_take),
    .tail_req_i(tail_req),
    .tail_done_o(tail_done),
    .trace_data_o(trace_data_o),
    .trace_ctl_o(trace_valid_control_pin_o)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    fmt = mode_i != tsf_pkg::TSF_MODE_BYPASS;
    next_inq_v = inq_v;
    next_inq_id = inq_id;
    next_inq_data = inq_data;
    next_hold_v = hold_v;
    next_hold_id = hold_id;
    next_hold_data = hold_data;
    next_pos = pos;
    next_cur_id = cur_id;
    next_fb = fb;
    next_aux = aux;
    next_full = full;
    next_old_ok = old_ok;
    next_force_rep = force_rep;
    next_rep_cnt = rep_cnt;
    next_trig_pend = trig_pend;
    next_trig_id_q = trig_id_q;
    next_flush_pend = flush_pend;
    next_resp_sent = resp_sent;
    next_tail_req = tail_req;
    next_flush_done = 1'b0;
    wr = 1'b0;
    wbyte = 8'h00;
    waux = 1'b0;
    id_wr = 1'b0;
    consume = 1'b0;
    frame_done = 1'b0;
    tgt = tsf_pkg::TSF_ID_NULL;

    // lookahead item: trigger first, then queued trace, then flush response
    p_v = 1'b1;
    p_src = 2'h0;
    p_id = tsf_pkg::TSF_ID_TRIG;
    p_data = trig_id_q;
    if (fmt && trig_pend) begin
      p_src = 2'h1;
    end else if (fmt && inq_v) begin
      p_src = 2'h2;
      p_id = inq_id;
      p_data = inq_data;
    end else if (fmt && flush_pend && !resp_sent) begin
      p_src = 2'h3;
      p_id = tsf_pkg::TSF_ID_FLUSH;
      p_data = tsf_pkg::TSF_FLUSH_ALL;
    end else begin
      p_v = 1'b0;
    end

    if (frame_take) begin
      next_full = 1'b0;
    end

    // slot writer, one slot per cycle
    if (fmt && !full) begin
      if (!pos[0]) begin
        if (hold_v && hold_id != cur_id) begin
          wr = 1'b1;
          wbyte = tsf_pkg::tsf_id_byte(hold_id);
          id_wr = 1'b1;
          next_cur_id = hold_id;
        end else if (hold_v && pos != tsf_pkg::TSF_SLOT_LAST && (p_v ? p_id != cur_id
                     : (flush_pend && cur_id != tsf_pkg::TSF_ID_NULL))) begin
          // announce the next ID early; the odd slot still carries the held old byte
          tgt = p_v ? p_id : tsf_pkg::TSF_ID_NULL;
          wr = 1'b1;
          wbyte = tsf_pkg::tsf_id_byte(tgt);
          waux = 1'b1;
          id_wr = 1'b1;
          next_cur_id = tgt;
          next_old_ok = 1'b1;
        end else if (hold_v && force_rep) begin
          wr = 1'b1;
          wbyte = tsf_pkg::tsf_id_byte(cur_id);
          id_wr = 1'b1;
        end else if (hold_v && (p_v || pos == tsf_pkg::TSF_SLOT_LAST)) begin
          wr = 1'b1;
          wbyte = {hold_data[7:1], 1'b0};
          waux = hold_data[0];
          consume = 1'b1;
        end else if (!hold_v && flush_pend) begin
          wr = 1'b1;
          if (cur_id != tsf_pkg::TSF_ID_NULL) begin
            wbyte = tsf_pkg::tsf_id_byte(tsf_pkg::TSF_ID_NULL);
            id_wr = 1'b1;
            next_cur_id = tsf_pkg::TSF_ID_NULL;
          end else begin
            wbyte = tsf_pkg::TSF_NULL_DATA;
          end
        end
      end else begin
        if (hold_v && (hold_id == cur_id || old_ok)) begin
          wr = 1'b1;
          wbyte = hold_data;
          consume = 1'b1;
          next_old_ok = 1'b0;
        end else if (cur_id == tsf_pkg::TSF_ID_NULL) begin
          wr = 1'b1;
          wbyte = tsf_pkg::TSF_NULL_DATA;
        end
      end
    end

    if (wr) begin
      next_fb[pos] = wbyte;
      if (!pos[0]) begin
        next_aux[pos[3:1]] = waux;
      end
      if (pos == tsf_pkg::TSF_SLOT_LAST) begin
        next_pos = 4'h0;
        next_full = 1'b1;
        frame_done = 1'b1;
      end else begin
        next_pos = pos + 4'h1;
      end
    end

    // held byte refill from the lookahead item
    if (consume) begin
      next_hold_v = 1'b0;
    end
    if ((consume || !hold_v) && p_v && fmt) begin
      next_hold_v = 1'b1;
      next_hold_id = p_id;
      next_hold_data = p_data;
      unique case (p_src)
        2'h1: next_trig_pend = 1'b0;
        2'h2: next_inq_v = 1'b0;
        2'h3: next_resp_sent = 1'b1;
        2'h0: next_hold_v = hold_v && !consume;
      endcase
    end

    // periodic ID repeat
    if (id_wr) begin
      next_rep_cnt = 8'h00;
      next_force_rep = 1'b0;
    end else if (frame_done) begin
      next_rep_cnt = rep_cnt + 8'h01;
      if (rep_cnt >= REP_LAST) begin
        next_force_rep = 1'b1;
      end
    end

    // formatted flush ends once the response is out and the frame is closed
    if (fmt && frame_done && flush_pend && next_resp_sent && !next_hold_v) begin
      next_flush_pend = 1'b0;
      next_resp_sent = 1'b0;
      next_flush_done = 1'b1;
    end

    // bypass path and bypass flush tail
    if (!fmt && byp_take) begin
      next_inq_v = 1'b0;
    end
    if (!fmt && flush_pend && !inq_v && !tail_req) begin
      next_tail_req = 1'b1;
    end
    if (tail_done) begin
      next_tail_req = 1'b0;
      next_flush_pend = 1'b0;
      next_flush_done = 1'b1;
    end

    // capture from sources; reserved and null IDs are dropped outside bypass mode
    if (src_ready_o && src_valid_i && (!fmt || tsf_pkg::tsf_id_usable(src_id_i))) begin
      next_inq_v = 1'b1;
      next_inq_id = src_id_i;
      next_inq_data = src_data_i;
    end
    if (trig_valid_i && fmt) begin
      next_trig_pend = 1'b1;
      next_trig_id_q = trig_id_i;
    end
    if (flush_i) begin
      next_flush_pend = 1'b1;
    end
    next_src_ready = !next_inq_v && !(!fmt && next_flush_pend);
  end

  // pack the frame, byte 0 lowest, aux byte last
  always_comb begin
    frame_bus = 128'h0;
    for (int i = 0; i < 15; i++) begin
      frame_bus[i*8 +: 8] = fb[i];
    end
    frame_bus[127:120] = aux;
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inq_v <= 1'b0;
      inq_id <= tsf_pkg::TSF_RST_ID;
      inq_data <= 8'h00;
      src_ready_o <= 1'b0;
      hold_v <= 1'b0;
      hold_id <= tsf_pkg::TSF_RST_ID;
      hold_data <= 8'h00;
      pos <= 4'h0;
      cur_id <= tsf_pkg::TSF_RST_ID;
      for (int i = 0; i < 15; i++) begin
        fb[i] <= 8'h00;
      end
      aux <= 8'h00;
      full <= 1'b0;
      old_ok <= 1'b0;
      force_rep <= 1'b0;
      rep_cnt <= tsf_pkg::TSF_RST_CNT;
      trig_pend <= 1'b0;
      trig_id_q <= 8'h00;
      flush_pend <= 1'b0;
      resp_sent <= 1'b0;
      tail_req <= 1'b0;
      flush_done_o <= 1'b0;
    end else if (ce_i) begin
      inq_v <= next_inq_v;
      inq_id <= next_inq_id;
      inq_data <= next_inq_data;
      src_ready_o <= next_src_ready;
      hold_v <= next_hold_v;
      hold_id <= next_hold_id;
      hold_data <= next_hold_data;
      pos <= next_pos;
      cur_id <= next_cur_id;
      fb <= next_fb;
      aux <= next_aux;
      full <= next_full;
      old_ok <= next_old_ok;
      force_rep <= next_force_rep;
      rep_cnt <= next_rep_cnt;
      trig_pend <= next_trig_pend;
      trig_id_q <= next_trig_id_q;
      flush_pend <= next_flush_pend;
      resp_sent <= next_resp_sent;
      tail_req <= next_tail_req;
      flush_done_o <= next_flush_done;
    end
  end

endmodule : tsf_formatter
`default_nettype wire

// ===== rtl/tsf_out.sv
// Output sequencer: frame syncs, frames, halfword idles, bypass bytes, bypass tail.
`timescale 1ns/1ps
`default_nettype none
module tsf_out #(
  parameter int FSYNC_FRAMES = tsf_pkg::TSF_FSYNC_FRAMES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [1:0] mode_i,
  input wire logic frame_valid_i,
  input wire logic [127:0] frame_i,
  output logic frame_take_o,
  input wire logic byp_valid_i,
  input wire logic [7:0] byp_data_i,
  output logic byp_take_o,
  input wire logic tail_req_i,
  output logic tail_done_o,
  output logic [7:0] trace_data_o,
  output logic trace_ctl_o
);

  localparam logic [7:0] FS_RELOAD = 8'(FSYNC_FRAMES - 1);

  tsf_pkg::tsf_ostate_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [127:0] frame_q, next_frame_q;
  logic [7:0] byp_q, next_byp_q;
  logic [1:0] wpos, next_wpos;
  logic [7:0] fs_cnt, next_fs_cnt;
  logic [7:0] cur_byte;
  logic cur_valid;
  logic free;
  logic byp_mode;
  logic cont_mode;

  // ==========================================================
  // sequencing
  always_comb begin
    byp_mode = mode_i == tsf_pkg::TSF_MODE_BYPASS;
    cont_mode = mode_i == tsf_pkg::TSF_MODE_CONT;
    next_state = state;
    next_cnt = cnt + 4'h1;
    next_frame_q = frame_q;
    next_byp_q = byp_q;
    next_fs_cnt = fs_cnt;
    frame_take_o = 1'b0;
    byp_take_o = 1'b0;
    tail_done_o = 1'b0;
    cur_valid = state != tsf_pkg::TSF_OS_IDLE;
    cur_byte = 8'h00;
    free = 1'b0;
    unique case (state)
      tsf_pkg::TSF_OS_IDLE: begin
        free = 1'b1;
      end
      tsf_pkg::TSF_OS_SYNC: begin
        cur_byte = tsf_pkg::TSF_FSYNC_WORD[{cnt[1:0], 3'b000} +: 8];
        if (cnt == tsf_pkg::TSF_SYNC_LAST) begin
          next_state = tsf_pkg::TSF_OS_FRAME;
          next_cnt = 4'h0;
        end
      end
      tsf_pkg::TSF_OS_FRAME: begin
        cur_byte = frame_q[{cnt, 3'b000} +: 8];
        free = cnt == tsf_pkg::TSF_FRAME_LAST;
      end
      tsf_pkg::TSF_OS_HSYNC: begin
        cur_byte = tsf_pkg::TSF_HSYNC_HALF[{cnt[0], 3'b000} +: 8];
        free = cnt[0];
      end
      tsf_pkg::TSF_OS_BYP: begin
        cur_byte = byp_q;
        free = 1'b1;
      end
      tsf_pkg::TSF_OS_TAIL: begin
        cur_byte = (cnt == 4'h0) ? tsf_pkg::TSF_TAIL_MARK : 8'h00;
        free = wpos == 2'h3;
        tail_done_o = free && ce_i;
      end
      default: begin
        free = 1'b1;
        cur_valid = 1'b0;
      end
    endcase
    if (free) begin
      next_state = tsf_pkg::TSF_OS_IDLE;
      next_cnt = 4'h0;
      if (!byp_mode && frame_valid_i) begin
        frame_take_o = ce_i;
        next_frame_q = frame_i;
        if (fs_cnt == 8'h00) begin
          next_state = tsf_pkg::TSF_OS_SYNC;
          next_fs_cnt = FS_RELOAD;
        end else begin
          next_state = tsf_pkg::TSF_OS_FRAME;
          next_fs_cnt = fs_cnt - 8'h01;
        end
      end else if (byp_mode && byp_valid_i) begin
        byp_take_o = ce_i;
        next_byp_q = byp_data_i;
        next_state = tsf_pkg::TSF_OS_BYP;
      end else if (byp_mode && tail_req_i && state != tsf_pkg::TSF_OS_TAIL) begin
        next_state = tsf_pkg::TSF_OS_TAIL;
      end else if (cont_mode && (wpos[0] == cur_valid)) begin
        // parity after this cycle's byte; an idle gap here would leak a 00 byte
        next_state = tsf_pkg::TSF_OS_HSYNC;
      end
    end
    next_wpos = cur_valid ? wpos + 2'h1 : wpos;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= tsf_pkg::TSF_OS_IDLE;
      cnt <= 4'h0;
      frame_q <= 128'h0;
      byp_q <= 8'h00;
      wpos <= 2'h0;
      fs_cnt <= tsf_pkg::TSF_RST_CNT;
      trace_data_o <= 8'h00;
      trace_ctl_o <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      cnt <= next_cnt;
      frame_q <= next_frame_q;
      byp_q <= next_byp_q;
      wpos <= next_wpos;
      fs_cnt <= next_fs_cnt;
      trace_data_o <= cur_byte;
      trace_ctl_o <= cur_valid && !cont_mode;
    end
  end

endmodule : tsf_out
`default_nettype wire

// ===== verif/tsf_capture_model.sv
// Behavioural trace capture analyser: records and unpacks the output stream.
`timescale 1ns/1ps
`default_nettype none
module tsf_capture_model (
  input wire logic core_clk_i,
  input wire logic ce_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] trace_data_i,
  input wire logic trace_valid_control_pin_i
);
  logic [7:0] cap_q[$];
  logic [7:0] frm_q[$];
  int hw_count;
  // ==========
  // capture: pin qualifies bytes except in continuous mode
  always @(posedge core_clk_i) begin
    if (ce_i && (trace_valid_control_pin_i || mode_i == 2'h2)) begin
      cap_q.push_back(trace_data_i);
    end
  end
  function automatic logic fsync_at(input int i);
    return i + 3 < cap_q.size() && cap_q[i] == 8'hFF && cap_q[i + 1] == 8'hFF
      && cap_q[i + 2] == 8'hFF && cap_q[i + 3] == 8'h7F;
  endfunction : fsync_at
  // ==========
  // unpack: wait for a sync, drop syncs and idle halfwords
  task automatic unpack();
    int i;
    i = 0;
    frm_q = {};
    hw_count = 0;
    while (i < cap_q.size() && !fsync_at(i)) i++;
    while (i + 1 < cap_q.size()) begin
      if (fsync_at(i)) begin
        i += 4;
      end else if (cap_q[i] == 8'hFF && cap_q[i + 1] == 8'h7F) begin
        hw_count++;
        i += 2;
      end else if (i + 15 < cap_q.size()) begin
        for (int k = 0; k < 16; k++) frm_q.push_back(cap_q[i + k]);
        i += 16;
      end else begin
        break;
      end
    end
  endtask : unpack
endmodule : tsf_capture_model
`default_nettype wire

// ===== verif/tsf_formatter_chk.sv
// Assertion checker for the trace stream formatter ports.
`timescale 1ns/1ps
`default_nettype none
module tsf_formatter_chk #(
  parameter int FSYNC_FRAMES = tsf_pkg::TSF_FSYNC_FRAMES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [1:0] mode_i,
  input wire logic src_valid_i,
  input wire logic [6:0] src_id_i,
  input wire logic src_ready_o,
  input wire logic flush_done_o,
  input wire logic [7:0] trace_data_o,
  input wire logic trace_valid_control_pin_o
);
  // ==========
  // stream position tracker (normal mode)
  logic byte_ok, ev_frm, in_sync, next_in_sync, b14_id, next_b14_id;
  logic [3:0] pos, next_pos;
  int fcnt, next_fcnt;
  assign byte_ok = ce_i && trace_valid_control_pin_o && (mode_i == tsf_pkg::TSF_MODE_NORMAL);
  assign ev_frm = byte_ok && !in_sync && !pos[0];
  always_comb begin
    next_in_sync = in_sync;
    next_pos = pos;
    next_fcnt = fcnt;
    next_b14_id = b14_id;
    if (byte_ok) begin
      next_pos = pos + 4'h1;
      if (in_sync && pos == 4'h3) begin
        next_in_sync = 1'b0;
        next_pos = 4'h0;
      end
      if (!in_sync && pos == 4'hE) begin
        next_b14_id = trace_data_o[0];
      end
      if (!in_sync && pos == 4'hF) begin
        next_fcnt = (fcnt + 1 == FSYNC_FRAMES) ? 0 : fcnt + 1;
        next_in_sync = (fcnt + 1 == FSYNC_FRAMES);
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_sync <= 1'b1;
      pos <= 4'h0;
      fcnt <= 0;
      b14_id <= 1'b0;
    end else begin
      in_sync <= next_in_sync;
      pos <= next_pos;
      fcnt <= next_fcnt;
      b14_id <= next_b14_id;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_sync_word;
    byte_ok && in_sync |-> trace_data_o == ((pos == 4'h3) ? 8'h7F : 8'hFF);
  endproperty
  a_sync_word: assert property (p_sync_word) else $error("bad frame sync byte");
  property p_no_ff_id;
    ev_frm |-> trace_data_o != 8'hFF;
  endproperty
  a_no_ff_id: assert property (p_no_ff_id) else $error("sync id in frame");
  property p_no_rsv;
    ev_frm && trace_data_o[0] |-> !(trace_data_o[7:1] inside {[7'h70:7'h7A], 7'h7C, 7'h7E});
  endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved id emitted");
  property p_aux14;
    byte_ok && !in_sync && pos == 4'hF && b14_id |-> !trace_data_o[7];
  endproperty
  a_aux14: assert property (p_aux14) else $error("aux bit of byte 14 set");
  property p_unit_run;
    byte_ok && !(!in_sync && pos == 4'hF) |=> trace_valid_control_pin_o;
  endproperty
  a_unit_run: assert property (p_unit_run) else $error("unit broken off");
  property p_cont_dark;
    mode_i == tsf_pkg::TSF_MODE_CONT |-> !trace_valid_control_pin_o;
  endproperty
  a_cont_dark: assert property (p_cont_dark) else $error("pin used in continuous");
  property p_done_pulse;
    flush_done_o && ce_i |=> !flush_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("flush done too long");
  property p_take_gap;
    ce_i && src_valid_i && src_ready_o
      && (mode_i == tsf_pkg::TSF_MODE_BYPASS || tsf_pkg::tsf_id_usable(src_id_i))
      |=> !src_ready_o;
  endproperty
  a_take_gap: assert property (p_take_gap) else $error("ready held after take");
endmodule : tsf_formatter_chk
bind tsf_formatter tsf_formatter_chk #(.FSYNC_FRAMES(FSYNC_FRAMES)) u_chk (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .ce_i(ce_i),
  .mode_i(mode_i),
  .src_valid_i(src_valid_i),
  .src_id_i(src_id_i),
  .src_ready_o(src_ready_o),
  .flush_done_o(flush_done_o),
  .trace_data_o(trace_data_o),
  .trace_valid_control_pin_o(trace_valid_control_pin_o)
);
`default_nettype wire

// ===== verif/tsf_formatter_tb.sv
// Self-checking testbench for the trace stream formatter.
`timescale 1ns/1ps
`default_nettype none
module tsf_formatter_tb;
  logic core_clk_i = 1'b0;
  logic rst_n_i, ce_i, src_valid_i, src_ready_o, trig_valid_i, flush_i, flush_done_o, ctl;
  logic [1:0] mode_i;
  logic [6:0] src_id_i;
  logic [7:0] src_data_i, trig_id_i, trace_data_o;
  logic [14:0] got_q[$], exp_q[$];
  int err_count, samples_checked, id_hits;
  // keep bit, source id, data
  localparam logic [15:0] ROWS [16] = '{16'h83AA, 16'h83A6, 16'h83A7, 16'h9555, 16'h9552,
    16'h9553, 16'h9554, 16'h7F11, 16'h83CA, 16'h83C6, 16'h7022, 16'h0033, 16'h7E44,
    16'h9501, 16'h8302, 16'h9503};
  localparam logic [7:0] BYP [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h01, 8'h00, 8'h00};
  always #5 core_clk_i = ~core_clk_i;
  tsf_formatter #(.ID_REPEAT_FRAMES(2), .FSYNC_FRAMES(2)) DUT (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .mode_i(mode_i),
    .src_valid_i(src_valid_i), .src_id_i(src_id_i), .src_data_i(src_data_i),
    .src_ready_o(src_ready_o), .trig_valid_i(trig_valid_i), .trig_id_i(trig_id_i),
    .flush_i(flush_i), .flush_done_o(flush_done_o), .trace_data_o(trace_data_o),
    .trace_valid_control_pin_o(ctl)
  );
  tsf_capture_model u_cap (.core_clk_i(core_clk_i), .ce_i(ce_i), .mode_i(mode_i),
    .trace_data_i(trace_data_o), .trace_valid_control_pin_i(ctl));
  // ==========
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic restart(input logic [1:0] m);
    @(negedge core_clk_i);
    rst_n_i = 1'b0;
    mode_i = m;
    repeat (3) @(negedge core_clk_i);
    check({ctl, trace_data_o, flush_done_o, src_ready_o}, 32'h0);
    rst_n_i = 1'b1;
    u_cap.cap_q = {};
    exp_q = {};
  endtask : restart
  task automatic send(input logic [6:0] id, input logic [7:0] d);
    int w;
    w = 0;
    @(negedge core_clk_i);
    while (src_ready_o !== 1'b1 && w < 100) begin
      @(negedge core_clk_i);
      w++;
    end
    src_valid_i = 1'b1;
    src_id_i = id;
    src_data_i = d;
    @(negedge core_clk_i);
    src_valid_i = 1'b0;
  endtask : send
  task automatic trig(input logic [7:0] t);
    @(negedge core_clk_i);
    trig_valid_i = 1'b1;
    trig_id_i = t;
    @(negedge core_clk_i);
    trig_valid_i = 1'b0;
  endtask : trig
  task automatic flush_wait();
    int w;
    w = 0;
    @(negedge core_clk_i);
    flush_i = 1'b1;
    @(negedge core_clk_i);
    flush_i = 1'b0;
    while (flush_done_o !== 1'b1 && w < 2000) begin
      @(negedge core_clk_i);
      w++;
    end
    check(flush_done_o, 32'h1);
    repeat (60) @(negedge core_clk_i);
  endtask : flush_wait
  task automatic put(input logic [6:0] id, input logic [7:0] d);
    if (id !== 7'h00) got_q.push_back({id, d});
  endtask : put
  task automatic decode_cmp();
    logic [6:0] cur;
    logic [7:0] b;
    logic ax;
    cur = 7'h00;
    got_q = {};
    id_hits = 0;
    u_cap.unpack();
    for (int f = 0; f + 15 < u_cap.frm_q.size(); f += 16) begin
      for (int i = 0; i < 8; i++) begin
        b = u_cap.frm_q[f + 2 * i];
        ax = u_cap.frm_q[f + 15][i];
        if (b[0] && b[7:1] == 7'h21) id_hits++;
        if (b[0] && ax && i < 7) begin
          put(cur, u_cap.frm_q[f + 2 * i + 1]);
          cur = b[7:1];
        end else begin
          if (b[0]) cur = b[7:1];
          else put(cur, {b[7:1], ax});
          if (i < 7) put(cur, u_cap.frm_q[f + 2 * i + 1]);
        end
      end
    end
    check(got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) check(got_q[i], exp_q[i]);
  endtask : decode_cmp
  // ==========
  // sequence
  initial begin
    {src_valid_i, trig_valid_i, flush_i, src_id_i, src_data_i, trig_id_i} = '0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    mode_i = 2'h1;
    err_count = 0;
    samples_checked = 0;
    restart(tsf_pkg::TSF_MODE_NORMAL);
    trig(8'h5A);
    exp_q.push_back({7'h7D, 8'h5A});
    foreach (ROWS[r]) begin
      send(ROWS[r][14:8], ROWS[r][7:0]);
      if (ROWS[r][15]) exp_q.push_back(ROWS[r][14:0]);
    end
    @(negedge core_clk_i);
    ce_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    ce_i = 1'b1;
    for (int n = 0; n < 60; n++) begin
      send(7'h21, n[7:0]);
      exp_q.push_back({7'h21, n[7:0]});
    end
    flush_wait();
    exp_q.push_back({7'h7B, 8'h00});
    decode_cmp();
    check(id_hits >= 2, 32'h1);
    check(u_cap.hw_count, 32'h0);
    restart(tsf_pkg::TSF_MODE_CONT);
    repeat (20) @(negedge core_clk_i);
    trig(8'h00);
    exp_q.push_back({7'h7D, 8'h00});
    for (int n = 0; n < 3; n++) begin
      send(7'h15, 8'hC0 + n[7:0]);
      exp_q.push_back({7'h15, 8'hC0 + n[7:0]});
    end
    flush_wait();
    exp_q.push_back({7'h7B, 8'h00});
    decode_cmp();
    check(u_cap.hw_count > 0, 32'h1);
    restart(tsf_pkg::TSF_MODE_BYPASS);
    trig(8'h33);
    for (int n = 0; n < 5; n++) send(7'h03, BYP[n]);
    flush_wait();
    check(u_cap.cap_q.size(), 32'h8);
    foreach (BYP[i]) if (i < u_cap.cap_q.size()) check(u_cap.cap_q[i], BYP[i]);
    report_and_stop();
  end
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule : tsf_formatter_tb
`default_nettype wire
